// file: logic/flash_host_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - After 90, address bit zero picks code
// - Write 70, then reads return status
// - Second program write carries location and value
// - Erase is 20 then D0 inside block
// - Upper data byte ignored, still driven valid
// - Status bits two to zero are reserved
module flash_host_ctrl #(
	parameter int ADDR_WIDTH = 17,
	parameter int DATA_WIDTH = 16
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// User request
	input  wire logic                  op_start,
	input  wire logic [2:0]            op_code,
	input  wire logic [ADDR_WIDTH-1:0] op_addr,
	input  wire logic [DATA_WIDTH-1:0] op_data,
	// User answer
	output logic                       op_busy,
	output logic                       op_done,
	output logic                       op_error,
	output logic [DATA_WIDTH-1:0]      rd_data,
	output logic [7:0]                 status_value,
	// Flash pins
	output logic [ADDR_WIDTH-1:0]      flash_addr,
	output logic [DATA_WIDTH-1:0]      flash_dq_out,
	output logic                       flash_dq_oe,
	input  wire logic [DATA_WIDTH-1:0] flash_dq_in,
	output logic                       flash_ce_n,
	output logic                       flash_oe_n,
	output logic                       flash_we_n
);
	import flash_host_pkg::*;

	state_t                  state_reg;	// Bus engine state
	logic [3:0]              timer_reg;	// Cycles left in the current phase
	logic [1:0]              phase_reg;	// Which write of the sequence ran last
	logic [2:0]              op_reg;	// Latched operation
	logic [ADDR_WIDTH-1:0]   op_addr_reg;	// Latched location
	logic [DATA_WIDTH-1:0]   op_data_reg;	// Latched program value
	logic                    op_busy_reg;
	logic                    op_done_reg;
	logic                    op_error_reg;
	logic [DATA_WIDTH-1:0]   rd_data_reg;
	logic [7:0]              status_reg;
	logic [ADDR_WIDTH-1:0]   flash_addr_reg;
	logic [DATA_WIDTH-1:0]   flash_dq_out_reg;
	logic                    flash_dq_oe_reg;
	logic                    flash_ce_n_reg;
	logic                    flash_oe_n_reg;
	logic                    flash_we_n_reg;

	// First command byte of each operation; program uses the main setup code
	wire logic [7:0] cmd_code =
		(op_reg == OP_READ_ARRAY) ? CMD_READ_ARRAY :
		(op_reg == OP_IDENT)      ? CMD_IDENT :
		(op_reg == OP_STATUS)     ? CMD_READ_STATUS :
		(op_reg == OP_CLEAR)      ? CMD_CLEAR :
		(op_reg == OP_PROGRAM)    ? CMD_PROG_SETUP :
		(op_reg == OP_ERASE)      ? CMD_ERASE_SETUP :
		(op_reg == OP_SUSPEND)    ? CMD_SUSPEND : CMD_CONFIRM;

	// Upper byte held at a fixed level during commands to keep current low
	wire logic [DATA_WIDTH-1:0] cmd_word = {UPPER_BYTE_IDLE, cmd_code};
	wire logic [DATA_WIDTH-1:0] poll_word = {UPPER_BYTE_IDLE, CMD_READ_STATUS};
	// Second write: program value, or erase confirm at the same block
	wire logic [DATA_WIDTH-1:0] second_word = (op_reg == OP_PROGRAM) ? op_data_reg :
		{UPPER_BYTE_IDLE, CMD_CONFIRM};

	// Identifier reads drive only address bit zero; the rest stay low
	wire logic [ADDR_WIDTH-1:0] read_addr = (op_reg == OP_IDENT) ?
		{{(ADDR_WIDTH-1){1'b0}}, op_addr_reg[0]} : op_addr_reg;

	// What follows a finished write
	wire logic is_read_op = (op_reg == OP_READ_ARRAY) || (op_reg == OP_IDENT) ||
		(op_reg == OP_STATUS);
	wire logic is_two_write = (op_reg == OP_PROGRAM) || (op_reg == OP_ERASE);
	wire logic go_read = (phase_reg == PH_POLL) || ((phase_reg == PH_CMD) && is_read_op);
	wire logic go_second = (phase_reg == PH_CMD) && is_two_write;
	wire logic go_poll = (phase_reg == PH_SECOND) ||
		((phase_reg == PH_CMD) && (op_reg == OP_SUSPEND));

	// Polling ends once the sequencer reports ready; bit six rides along for suspend
	wire logic seq_ready = rd_data_reg[SR_READY_BIT];
	wire logic [7:0] status_seen = flash_dq_in[7:0] & SR_USED_MASK;
	wire logic status_read = (phase_reg == PH_POLL) || (op_reg == OP_STATUS);
	// Any of the sticky failure bits; they hold every failure since the last clear
	wire logic fail_seen = rd_data_reg[SR_ERASE_FAIL] | rd_data_reg[SR_PROG_FAIL] |
		rd_data_reg[SR_VOLT_LOW];
	wire logic timer_zero = (timer_reg == 4'h0);

	// Bus engine: each bus cycle is a timed low phase then a recovery phase
	always_ff @(posedge sys_clk) begin
		op_done_reg <= 1'b0;
		if (reset) begin
			state_reg        <= ST_IDLE;
			timer_reg        <= 4'h0;
			phase_reg        <= PH_CMD;
			op_reg           <= OP_READ_ARRAY;
			op_addr_reg      <= '0;
			op_data_reg      <= '0;
			op_busy_reg      <= 1'b0;
			op_error_reg     <= 1'b0;
			rd_data_reg      <= '0;
			status_reg       <= 8'h00;
			flash_addr_reg   <= '0;
			flash_dq_out_reg <= '0;
			flash_dq_oe_reg  <= 1'b0;
			flash_ce_n_reg   <= 1'b1;
			flash_oe_n_reg   <= 1'b1;
			flash_we_n_reg   <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// Latch the request and start the command write
					if (op_start) begin
						op_reg           <= op_code;
						op_addr_reg      <= op_addr;
						op_data_reg      <= op_data;
						op_busy_reg      <= 1'b1;
						phase_reg        <= PH_CMD;
						state_reg        <= ST_WR_LOW;
						timer_reg        <= WE_LOW_CYC - 4'h1;
						flash_addr_reg   <= op_addr;
						flash_dq_out_reg <= {UPPER_BYTE_IDLE, 8'h00};
						flash_dq_oe_reg  <= 1'b1;
						flash_ce_n_reg   <= 1'b0;
						flash_we_n_reg   <= 1'b0;
					end
				end
				ST_WR_LOW: begin
					// Data must be on the pins while the write strobe is low
					if (phase_reg == PH_CMD && timer_reg == WE_LOW_CYC - 4'h1)
						flash_dq_out_reg <= cmd_word;
					if (timer_zero) begin
						flash_we_n_reg <= 1'b1;
						flash_ce_n_reg <= 1'b1;
						timer_reg      <= RECOVER_CYC - 4'h1;
						state_reg      <= ST_WR_HIGH;
					end else begin
						timer_reg <= timer_reg - 4'h1;
					end
				end
				ST_WR_HIGH: begin
					// Data held through recovery, then choose the next bus cycle
					if (!timer_zero) begin
						timer_reg <= timer_reg - 4'h1;
					end else if (go_second || go_poll) begin
						phase_reg        <= go_second ? PH_SECOND : PH_POLL;
						flash_dq_out_reg <= go_second ? second_word : poll_word;
						flash_addr_reg   <= op_addr_reg;
						flash_ce_n_reg   <= 1'b0;
						flash_we_n_reg   <= 1'b0;
						timer_reg        <= WE_LOW_CYC - 4'h1;
						state_reg        <= ST_WR_LOW;
					end else if (go_read) begin
						flash_dq_oe_reg <= 1'b0;
						flash_addr_reg  <= read_addr;
						flash_ce_n_reg  <= 1'b0;
						flash_oe_n_reg  <= 1'b0;
						timer_reg       <= ACCESS_CYC - 4'h1;
						state_reg       <= ST_RD_LOW;
					end else begin
						flash_dq_oe_reg <= 1'b0;
						op_busy_reg     <= 1'b0;
						op_done_reg     <= 1'b1;
						op_error_reg    <= 1'b0;
						state_reg       <= ST_IDLE;
					end
				end
				ST_RD_LOW: begin
					// Sample at the end of the access time, then release the bus
					if (timer_zero) begin
						rd_data_reg    <= flash_dq_in;
						if (status_read)
							status_reg <= status_seen;
						flash_oe_n_reg <= 1'b1;
						flash_ce_n_reg <= 1'b1;
						timer_reg      <= RECOVER_CYC - 4'h1;
						state_reg      <= ST_RD_HIGH;
					end else begin
						timer_reg <= timer_reg - 4'h1;
					end
				end
				ST_RD_HIGH: begin
					// Status is latched per strobe, so busy polls toggle OE again
					if (!timer_zero) begin
						timer_reg <= timer_reg - 4'h1;
					end else if (phase_reg == PH_POLL && !seq_ready) begin
						flash_ce_n_reg <= 1'b0;
						flash_oe_n_reg <= 1'b0;
						timer_reg      <= ACCESS_CYC - 4'h1;
						state_reg      <= ST_RD_LOW;
					end else begin
						op_busy_reg  <= 1'b0;
						op_done_reg  <= 1'b1;
						op_error_reg <= status_read && fail_seen;
						state_reg    <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign op_busy      = op_busy_reg;
	assign op_done      = op_done_reg;
	assign op_error     = op_error_reg;
	assign rd_data      = rd_data_reg;
	assign status_value = status_reg;
	assign flash_addr   = flash_addr_reg;
	assign flash_dq_out = flash_dq_out_reg;
	assign flash_dq_oe  = flash_dq_oe_reg;
	assign flash_ce_n   = flash_ce_n_reg;
	assign flash_oe_n   = flash_oe_n_reg;
	assign flash_we_n   = flash_we_n_reg;

	// Checks on the pin sequences and the user-side results
	property p_we_needs_ce;
		@(posedge sys_clk) disable iff (reset)
		!flash_we_n |-> (!flash_ce_n && flash_dq_oe && flash_oe_n);
	endproperty
	a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe without select");

	property p_cmd_upper_byte;
		@(posedge sys_clk) disable iff (reset)
		(!flash_we_n && (phase_reg != PH_SECOND)) |-> ##1 (flash_we_n || flash_dq_out[15:8] == 8'h00);
	endproperty
	a_cmd_upper_byte: assert property (p_cmd_upper_byte) else $error("upper byte not low");

	property p_we_width;
		@(posedge sys_clk) disable iff (reset)
		$fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

	property p_oe_width;
		@(posedge sys_clk) disable iff (reset)
		$fell(flash_oe_n) |-> (!flash_oe_n && !flash_dq_oe) [*6] ##1 flash_oe_n;
	endproperty
	a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");

	property p_ident_addr;
		@(posedge sys_clk) disable iff (reset)
		(!flash_oe_n && op_reg == OP_IDENT) |-> flash_addr[ADDR_WIDTH-1:1] == '0;
	endproperty
	a_ident_addr: assert property (p_ident_addr) else $error("identifier address not clean");

	property p_program_second;
		@(posedge sys_clk) disable iff (reset)
		($fell(flash_we_n) && phase_reg == PH_SECOND && op_reg == OP_PROGRAM)
			|-> (flash_dq_out == op_data_reg && flash_addr == op_addr_reg);
	endproperty
	a_program_second: assert property (p_program_second) else $error("program value wrong");

	property p_erase_confirm;
		@(posedge sys_clk) disable iff (reset)
		($fell(flash_we_n) && phase_reg == PH_SECOND && op_reg == OP_ERASE)
			|-> (flash_dq_out[7:0] == CMD_CONFIRM && flash_addr == op_addr_reg);
	endproperty
	a_erase_confirm: assert property (p_erase_confirm) else $error("erase confirm wrong");

	property p_status_masked;
		@(posedge sys_clk) disable iff (reset)
		op_done |-> (status_value[2:0] == 3'h0 && !op_busy) ##1 !op_done;
	endproperty
	a_status_masked: assert property (p_status_masked) else $error("reserved bits shown");

	property p_poll_until_ready;
		@(posedge sys_clk) disable iff (reset)
		(op_done && (op_reg == OP_PROGRAM || op_reg == OP_ERASE)) |-> status_value[7];
	endproperty
	a_poll_until_ready: assert property (p_poll_until_ready) else $error("done before ready");

endmodule : flash_host_ctrl

// file: logic/flash_host_pkg.sv
package flash_host_pkg;

	// Operations the user side may request
	localparam logic [2:0] OP_READ_ARRAY = 3'h0;	// Array read at op_addr
	localparam logic [2:0] OP_IDENT      = 3'h1;	// Identifier read, op_addr[0] picks code
	localparam logic [2:0] OP_STATUS     = 3'h2;	// One status read
	localparam logic [2:0] OP_CLEAR      = 3'h3;	// Clear the failure bits
	localparam logic [2:0] OP_PROGRAM    = 3'h4;	// Program op_data at op_addr, then poll
	localparam logic [2:0] OP_ERASE      = 3'h5;	// Erase the block holding op_addr, then poll
	localparam logic [2:0] OP_SUSPEND    = 3'h6;	// Suspend erase, then poll until ready
	localparam logic [2:0] OP_RESUME     = 3'h7;	// Resume a suspended erase

	// Command codes written on the low data byte
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_IDENT       = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR       = 8'h50;
	localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
	localparam logic [7:0] CMD_ALT_SETUP   = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;

	// Fields of operation_status
	localparam int         SR_READY_BIT     = 7;
	localparam int         SR_SUSPENDED_BIT = 6;
	localparam int         SR_ERASE_FAIL    = 5;
	localparam int         SR_PROG_FAIL     = 4;
	localparam int         SR_VOLT_LOW      = 3;
	localparam logic [7:0] SR_USED_MASK     = 8'hF8;
	localparam logic [7:0] UPPER_BYTE_IDLE  = 8'h00;

	// Sequence phases
	localparam logic [1:0] PH_CMD    = 2'h0;
	localparam logic [1:0] PH_SECOND = 2'h1;
	localparam logic [1:0] PH_POLL   = 2'h2;

	// Bus timing, in ns, and the cycle counts derived from the clock
	localparam int         CLK_PERIOD_NS = 20;
	localparam int         T_WE_LOW_NS   = 50;
	localparam int         T_RECOVER_NS  = 30;
	localparam int         T_ACCESS_NS   = 120;
	localparam logic [3:0] WE_LOW_CYC    = 4'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RECOVER_CYC   = 4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] ACCESS_CYC    = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Bus engine states
	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_WR_LOW  = 5'b00010,
		ST_WR_HIGH = 5'b00100,
		ST_RD_LOW  = 5'b01000,
		ST_RD_HIGH = 5'b10000
	} state_t;

endpackage : flash_host_pkg

// file: tb/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
	parameter logic [15:0] MAKER_CODE = 16'h00A5,	// Arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h005C	// Arbitrary value
) (
	// Host pins
	input  wire logic [16:0] addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	output logic      [15:0] dq_in,
	// Fault and speed controls from the bench
	input  wire logic        fail_prog,
	input  wire logic        fail_erase,
	input  wire logic        volt_low,
	input  wire logic [7:0]  busy_polls
);
	logic [15:0] mem [logic [16:0]];	// Sparse array, unwritten reads all ones
	logic [1:0]  mode = 2'h0;	// 0 array, 1 ident, 2 status
	logic        pend_prog = 1'b0;	// Program setup seen
	logic        pend_erase = 1'b0;	// Erase setup seen
	logic        erasing = 1'b0;	// Busy job is an erase
	logic        susp = 1'b0;	// Erase suspended
	logic [2:0]  fails = 3'h0;	// Erase fail, program fail, voltage low
	logic [7:0]  busy_cnt = 8'h00;	// Status reads left before ready
	logic [7:0]  sr_lat = 8'h80;	// Status latched at read start
	logic [15:0] rd_val;	// Word for the current read
	logic [15:0] rd_last = 16'h0000;	// Last word, inverted when released
	logic [16:0] last_prog_addr, last_erase_addr;	// Seen by the bench
	logic [15:0] last_prog_data;	// Seen by the bench
	wire         wr_n = ce_n | we_n;	// Write strobe, latches on rise
	wire         rd_n = ce_n | oe_n;	// Read strobe
	// Released bus must not keep the old word, else a late sample passes
	assign dq_in = rd_n ? ~rd_last : rd_val;
	// Read path: only address bit zero picks the identifier
	always @* begin
		if (mode == 2'h2)
			rd_val = {8'h00, sr_lat};
		else if (mode == 2'h1)
			rd_val = addr[0] ? PART_CODE : MAKER_CODE;
		else
			rd_val = mem.exists(addr) ? mem[addr] : 16'hFFFF;
	end
	always @(posedge rd_n) rd_last = rd_val;
	// Status latched on the falling strobe; completion applies faults
	always @(negedge rd_n) begin
		if (mode == 2'h2) begin
			if (busy_cnt != 8'h00 && !susp) begin
				busy_cnt = busy_cnt - 8'h01;
				if (busy_cnt == 8'h00 && volt_low)
					fails = fails | {erasing, 2'b01};
				else if (busy_cnt == 8'h00)
					fails = fails | {fail_erase & erasing, fail_prog & !erasing, 1'b0};
			end
			// Reserved bits carry junk the host must mask
			sr_lat = {busy_cnt == 8'h00 || susp, susp, fails, 3'b101};
		end
	end
	// Command decoder, low data byte only
	always @(posedge wr_n) begin
		if (pend_prog) begin
			mem[addr] = (mem.exists(addr) ? mem[addr] : 16'hFFFF) & dq_out;
			last_prog_addr = addr;
			last_prog_data = dq_out;
			{pend_prog, erasing, busy_cnt, mode} = {2'b00, busy_polls, 2'h2};
		end else if (pend_erase) begin
			last_erase_addr = addr;
			if (dq_out[7:0] == 8'hD0)
				{erasing, busy_cnt} = {1'b1, busy_polls};
			else
				fails = fails | 3'b110;
			{pend_erase, mode} = {1'b0, 2'h2};
		end else case (dq_out[7:0])
			8'hFF: mode = 2'h0;
			8'h90: mode = 2'h1;
			8'h70: mode = 2'h2;
			8'h50: fails = 3'h0;
			8'h40, 8'h10: pend_prog = 1'b1;
			8'h20: pend_erase = 1'b1;
			8'hB0: if (erasing && busy_cnt != 8'h00) {susp, mode} = {1'b1, 2'h2};
			8'hD0: if (susp) {susp, busy_cnt} = {1'b0, busy_polls};
			default: ;
		endcase
	end
endmodule : flash_dev_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import flash_host_pkg::*;
	// User side
	logic        sys_clk, reset, op_start, fail_prog, fail_erase, volt_low;
	logic [2:0]  op_code;
	logic [16:0] op_addr;
	logic [15:0] op_data;
	logic [7:0]  busy_polls;	// Device speed, in status reads
	wire         op_busy, op_done, op_error, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
	wire  [15:0] rd_data, flash_dq_out, flash_dq_in;
	wire  [7:0]  status_value;
	wire  [16:0] flash_addr;
	int          num_errors, tests_run, i;
	flash_host_ctrl flash_host_ctrl_i (.sys_clk(sys_clk), .reset(reset), .op_start(op_start),
		.op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_busy(op_busy),
		.op_done(op_done), .op_error(op_error), .rd_data(rd_data), .status_value(status_value),
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n));
	flash_dev_model flash_dev_model_i (.addr(flash_addr), .dq_out(flash_dq_out), .ce_n(flash_ce_n),
		.oe_n(flash_oe_n), .we_n(flash_we_n), .dq_in(flash_dq_in), .fail_prog(fail_prog),
		.fail_erase(fail_erase), .volt_low(volt_low), .busy_polls(busy_polls));
	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Verdict, the single end of the run
	task give_verdict;
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle request strobe
	task start_op(input logic [2:0] c, input logic [16:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{op_start, op_code, op_addr, op_data} <= {1'b1, c, a, d};
		@(posedge sys_clk);
		op_start <= 1'b0;
	endtask : start_op
	// Bounded wait; a hang is cut short as a failure
	task wait_done;
		for (i = 0; i < 4000; i++) begin
			@(posedge sys_clk);
			#1;
			if (op_done === 1'b1)
				return;
		end
		num_errors++;
		$display("mismatch at %0t: operation never finished", $time);
		give_verdict;
	endtask : wait_done
	task do_op(input logic [2:0] c, input logic [16:0] a, input logic [15:0] d);
		start_op(c, a, d);
		wait_done;
		chk({15'h0000, op_busy}, 16'h0000);
	endtask : do_op
	// Main sequence
	initial begin
		{op_start, op_code, op_addr, op_data, reset} = {1'b0, 3'h0, 17'h00000, 16'h0000, 1'b1};
		{fail_prog, fail_erase, volt_low, busy_polls} = {3'b000, 8'h03};
		{num_errors, tests_run} = {32'd0, 32'd0};
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		do_op(OP_IDENT, 17'h1FFFE, 16'h0000);
		chk(rd_data, 16'h00A5);
		do_op(OP_IDENT, 17'h00001, 16'h0000);
		chk(rd_data, 16'h005C);
		do_op(OP_STATUS, 17'h15555, 16'h0000);
		chk(rd_data, 16'h0085);
		chk(16'(status_value), 16'h0080);
		do_op(OP_PROGRAM, 17'h01234, 16'h5A3C);
		chk({15'h0000, op_error}, 16'h0000);
		chk(16'(flash_dev_model_i.last_prog_addr), 16'h1234);
		chk(flash_dev_model_i.last_prog_data, 16'h5A3C);
		do_op(OP_READ_ARRAY, 17'h01234, 16'h0000);
		chk(rd_data, 16'h5A3C);
		fail_prog = 1'b1;
		do_op(OP_PROGRAM, 17'h00010, 16'h0000);
		chk({op_error, 7'h00, status_value}, 16'h8090);
		fail_prog = 1'b0;
		do_op(OP_PROGRAM, 17'h00011, 16'h0000);
		chk({op_error, 7'h00, status_value}, 16'h8090);
		do_op(OP_CLEAR, 17'h00000, 16'h0000);
		do_op(OP_STATUS, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h0080);
		fail_erase = 1'b1;
		do_op(OP_ERASE, 17'h08123, 16'h0000);
		chk({op_error, 7'h00, status_value}, 16'h80A0);
		chk(16'(flash_dev_model_i.last_erase_addr), 16'h8123);
		{fail_erase, volt_low} = 2'b01;
		do_op(OP_CLEAR, 17'h00000, 16'h0000);
		do_op(OP_PROGRAM, 17'h00020, 16'h1111);
		chk(16'(status_value), 16'h0088);
		do_op(OP_CLEAR, 17'h00000, 16'h0000);
		do_op(OP_ERASE, 17'h00020, 16'h0000);
		chk(16'(status_value), 16'h00A8);
		volt_low = 1'b0;
		do_op(OP_CLEAR, 17'h00000, 16'h0000);
		do_op(OP_SUSPEND, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h0080);
		// Long erase cut by a host reset, then suspended and resumed
		busy_polls = 8'd200;
		start_op(OP_ERASE, 17'h10000, 16'h0000);
		repeat (60) @(posedge sys_clk);
		chk({15'h0000, op_busy}, 16'h0001);
		reset <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		// Strobes released and user side idle once reset has been seen
		chk({10'h000, op_busy, op_done, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe},
			16'h000E);
		do_op(OP_SUSPEND, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h00C0);
		do_op(OP_STATUS, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h00C0);
		busy_polls = 8'd2;
		do_op(OP_RESUME, 17'h00000, 16'h0000);
		do_op(OP_STATUS, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h0000);
		do_op(OP_STATUS, 17'h00000, 16'h0000);
		chk(16'(status_value), 16'h0080);
		give_verdict;
	end
endmodule : tb_top
